// file: core/ephs_top.sv
// request/grant handshake for an external port dma channel
// Summary of operation
// R1 - peripheral has write data ready, or takes read data, when grant arrives
// R2 - peripheral at full rate keeps short pipeline, gates fourth request on grant
// R3 - a one on the flush bit clears all pending requests
// R4 - bus held while request stays low after grant
// R5 - request released before grant gives a single cycle grant
// R6 - request pin is asynchronous, falling edge starts one request
// R7 - write data present before grant release; transfer stalls until request rises
// R8 - grant never earlier than three cycles after request; waits on priority, bus
// R9 - peripheral must not count on grant within two cycles
// R10 - up to seven unserviced requests are queued and serviced in turn
// R11 - peripheral tracks its own outstanding requests and grants
// R12 - no arbitration while buffer full on write or empty on read
// R13 - disabled channel holds grant high; requests ignored two cycles after enable
// R14 - peripheral holds request high while the channel is being enabled
// R15 - grant driven only by bus owner, released while host bus grant active
// R16 - grant follows strobe timing and bus suspend, host request
// R17 - extern mode is extern bit with handshake one and initiator zero
// R18 - extern mode drives address, selects, strobes; grant waits ack and waits
// R19 - extern mode uses no port buffer; address and count from index registers
// R20 - extern mode completion interrupt always raised, chain disable ignored
// R21 - extern mode does no packing or unpacking
// R22 - external latch uses grant as enable or rising edge capture
// R23 - handshake bit one with initiator zero answers requests with grant
// R24 - grant released the cycle after request rises, without pipelined requests
// R25 - counter holds seven; grants only for counted requests
// R26 - request passes a multi-stage synchroniser before edge detection
`timescale 1ns/1ps
`default_nettype none
`include "ephs_cfg.svh"
module ephs_top #(
    parameter int DATA_W = `EPHS_DATA_W,
    parameter int FIFO_DEPTH = `EPHS_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire ephs_pkg::ephs_ctrl_t ctrl,
    input wire ephs_pkg::ephs_bus_t bus,
    input wire logic xfer_request_n,
    input wire logic [`EPHS_WAIT_W-1:0] wait_states,
    input wire logic ext_load,
    input wire logic [`EPHS_ADDR_W-1:0] ext_index_in,
    input wire logic [`EPHS_ADDR_W-1:0] ext_modifier_in,
    input wire logic [`EPHS_CNT_W-1:0] ext_count_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic int_in_valid,
    input wire logic [DATA_W-1:0] int_in_data,
    output logic int_in_ready,
    output logic int_out_valid,
    output logic [DATA_W-1:0] int_out_data,
    input wire logic int_out_ready,
    output logic xfer_grant_n,
    output logic xfer_grant_oe,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output ephs_pkg::ephs_ext_t ext_bus,
    output logic bus_request,
    output logic done_irq,
    output logic [`EPHS_PEND_W-1:0] pending_count,
    output logic [`EPHS_CNT_W-1:0] words_left
);
    ephs_pkg::ephs_state_t state_reg;
    ephs_pkg::ephs_state_t state_next;
    logic req_s;
    logic req_d_reg;
    logic en_d_reg;
    logic en_rise;
    logic [1:0] ign_cnt_reg;
    logic [`EPHS_PEND_W-1:0] pend_reg;
    logic [`EPHS_WAIT_W-1:0] wait_cnt_reg;
    logic [`EPHS_ADDR_W-1:0] ext_index_reg;
    logic [`EPHS_ADDR_W-1:0] ext_modifier_reg;
    logic [`EPHS_CNT_W-1:0] ext_count_reg;
    logic hs_on;
    logic ext_on;
    logic accept;
    logic blocked;
    logic grant_go;
    logic xfer_end;
    logic ext_ok;
    logic f_in_valid;
    logic [DATA_W-1:0] f_in_data;
    logic f_in_ready;
    logic f_out_valid;
    logic f_out_ready;
    logic f_full;
    logic f_empty;

    function automatic logic bus_free(input ephs_pkg::ephs_bus_t b);
        bus_free = b.bus_owner && !b.host_bus_grant && !b.bus_suspend_in && !b.host_bus_request;
    endfunction : bus_free

    ////////////////////////////////////////////////////////////////////////////////
    // request capture
    // R26 - two stage synchroniser
    ephs_sync #(
        .STAGES(`EPHS_SYNC_STAGES)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .d(xfer_request_n),
        .q(req_s)
    );

    // R23 R17 - mode decode
    assign hs_on = ctrl.channel_enable_bit && ctrl.handshake_mode_bit && !ctrl.initiator_mode_bit;
    assign ext_on = hs_on && ctrl.extern_xfer_bit;
    assign en_rise = hs_on && !en_d_reg;
    // R6 R13 R25 - falling edge counted when not ignored
    assign accept = req_d_reg && !req_s && hs_on && !en_rise && (ign_cnt_reg == '0)
        && (pend_reg != `EPHS_PEND_W'(`EPHS_MAX_PEND));

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            req_d_reg <= 1'b1;
            en_d_reg <= 1'b0;
        end else begin
            req_d_reg <= req_s;
            en_d_reg <= hs_on;
        end
    end

    // R13 - ignore window after enable
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ign_cnt_reg <= '0;
        end else if (en_rise) begin
            ign_cnt_reg <= 2'(`EPHS_ENA_IGNORE_CYC - 1);
        end else if (ign_cnt_reg != '0) begin
            ign_cnt_reg <= ign_cnt_reg - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pending request counter
    // R3 R10 R25 - flush clears, new edge wins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= '0;
        end else if (!hs_on) begin
            pend_reg <= '0;
        end else if (ctrl.request_flush_bit) begin
            pend_reg <= `EPHS_PEND_W'(accept);
        end else begin
            pend_reg <= pend_reg + `EPHS_PEND_W'(accept)
                - `EPHS_PEND_W'(xfer_end && (pend_reg != '0));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // grant sequencing
    // R12 - blocked on full write or empty read buffer
    assign blocked = !ext_on && (ctrl.periph_writes ? f_full : f_empty);
    // R8 - priority and bus ownership delay grant
    assign grant_go = (state_reg == ephs_pkg::EPHS_ARB) && (pend_reg != '0) && !blocked
        && bus_free(bus) && !bus.prio_pending;
    // R18 - ack and wait states hold the grant
    assign ext_ok = !ext_on || (bus.ack && (wait_cnt_reg == '0));
    // R4 R7 R5 - end only once request high after grant
    assign xfer_end = (state_reg == ephs_pkg::EPHS_GRANT) && !xfer_grant_n && req_s
        && ext_ok && bus_free(bus);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ephs_pkg::EPHS_IDLE: begin
                if (pend_reg != '0) begin
                    state_next = ephs_pkg::EPHS_ARB;
                end
            end
            ephs_pkg::EPHS_ARB: begin
                if (grant_go) begin
                    state_next = ephs_pkg::EPHS_GRANT;
                end else if (pend_reg == '0) begin
                    state_next = ephs_pkg::EPHS_IDLE;
                end
            end
            ephs_pkg::EPHS_GRANT: begin
                // R24 - next pipelined request or idle
                if (xfer_end) begin
                    state_next = (pend_reg > `EPHS_PEND_W'(1)) ? ephs_pkg::EPHS_ARB
                        : ephs_pkg::EPHS_IDLE;
                end
            end
            default: begin
                state_next = ephs_pkg::EPHS_IDLE;
            end
        endcase
        if (!hs_on) begin
            state_next = ephs_pkg::EPHS_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ephs_pkg::EPHS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // R16 R24 R13 - grant low only in grant state on a free bus
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xfer_grant_n <= 1'b1;
            xfer_grant_oe <= 1'b0;
            bus_request <= 1'b0;
        end else begin
            xfer_grant_n <= !((state_next == ephs_pkg::EPHS_GRANT) && bus_free(bus));
            // R15 - drive only as bus owner
            xfer_grant_oe <= bus.bus_owner && !bus.host_bus_grant;
            // R12 - arbitrate only when unblocked
            bus_request <= (state_reg == ephs_pkg::EPHS_ARB) && !blocked && hs_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // external memory cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt_reg <= '0;
        end else if (grant_go) begin
            wait_cnt_reg <= wait_states;
        end else if (wait_cnt_reg != '0) begin
            wait_cnt_reg <= wait_cnt_reg - 1'b1;
        end
    end

    // R19 - address and count from preloaded registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_index_reg <= '0;
            ext_modifier_reg <= '0;
            ext_count_reg <= '0;
        end else if (ext_load) begin
            ext_index_reg <= ext_index_in;
            ext_modifier_reg <= ext_modifier_in;
            ext_count_reg <= ext_count_in;
        end else if (xfer_end && (ext_count_reg != '0)) begin
            ext_index_reg <= ext_index_reg + ext_modifier_reg;
            ext_count_reg <= ext_count_reg - 1'b1;
        end
    end
    assign words_left = ext_count_reg;

    // R18 R16 - address, selects and strobes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_bus.addr <= '0;
            ext_bus.memory_select_lines <= `EPHS_MS_IDLE;
            ext_bus.rd_n <= 1'b1;
            ext_bus.wr_n <= 1'b1;
        end else if (ext_on && (state_next == ephs_pkg::EPHS_GRANT) && bus_free(bus)) begin
            ext_bus.addr <= ext_index_reg;
            ext_bus.memory_select_lines <= `EPHS_MS_SEL;
            ext_bus.rd_n <= ctrl.periph_writes;
            ext_bus.wr_n <= !ctrl.periph_writes;
        end else begin
            ext_bus.addr <= '0;
            ext_bus.memory_select_lines <= `EPHS_MS_IDLE;
            ext_bus.rd_n <= 1'b1;
            ext_bus.wr_n <= 1'b1;
        end
    end

    // R20 - completion pulse, chain disable only outside extern mode
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            done_irq <= 1'b0;
        end else begin
            done_irq <= xfer_end && (ext_count_reg == `EPHS_CNT_W'(1))
                && (ext_on || !ctrl.chain_irq_disable);
        end
    end

    assign pending_count = pend_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // port buffer data path
    // R19 R21 - transfers bypass the buffer in extern mode; internal side still connected
    assign f_in_valid = ctrl.periph_writes ? (xfer_end && !ext_on) : int_in_valid;
    assign f_in_data = ctrl.periph_writes ? data_in : int_in_data;
    assign f_out_ready = ctrl.periph_writes ? int_out_ready : (xfer_end && !ext_on);
    assign int_in_ready = !ctrl.periph_writes && f_in_ready;
    assign int_out_valid = ctrl.periph_writes && f_out_valid;

    ephs_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_port_buffer_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(f_in_valid),
        .in_data(f_in_data),
        .in_ready(f_in_ready),
        .out_valid(f_out_valid),
        .out_data(int_out_data),
        .out_ready(f_out_ready),
        .full(f_full),
        .empty(f_empty)
    );

    // R1 - read word driven while granted
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            data_out <= '0;
            data_oe <= 1'b0;
        end else begin
            if (grant_go) begin
                data_out <= int_out_data;
            end
            data_oe <= (state_next == ephs_pkg::EPHS_GRANT) && !ctrl.periph_writes && !ext_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    flush_clears_a: assert property ( // R3
        ctrl.request_flush_bit && hs_on && !accept |=> pend_reg == '0)
        else $error("flush left pending requests");
    grant_latency_a: assert property ( // R8
        state_reg == ephs_pkg::EPHS_IDLE && pend_reg == '0 && $fell(xfer_request_n)
        |-> xfer_grant_n [*3])
        else $error("grant came too early");
    grant_hold_a: assert property ( // R4
        state_reg == ephs_pkg::EPHS_GRANT && !xfer_grant_n && !req_s && bus_free(bus) && hs_on
        |=> !xfer_grant_n)
        else $error("grant dropped while request low");
    grant_release_a: assert property ( // R24
        xfer_end |=> xfer_grant_n)
        else $error("grant not released after request rose");
    blocked_arb_a: assert property ( // R12
        state_reg == ephs_pkg::EPHS_ARB && blocked |=> !bus_request && xfer_grant_n)
        else $error("arbitration while blocked");
    disabled_grant_a: assert property ( // R13
        !ctrl.channel_enable_bit |=> xfer_grant_n && pend_reg == '0)
        else $error("grant active while disabled");
    enable_ignore_a: assert property ( // R13
        en_rise |=> (pend_reg == '0) [*2])
        else $error("request taken right after enable");
    grant_tristate_a: assert property ( // R15
        bus.host_bus_grant || !bus.bus_owner |=> !xfer_grant_oe)
        else $error("grant driven without bus");
    suspend_grant_a: assert property ( // R16
        state_reg == ephs_pkg::EPHS_GRANT && !bus_free(bus) |=> xfer_grant_n)
        else $error("grant kept during suspend");
    ext_no_data_a: assert property ( // R19
        ext_on && $past(ext_on) |-> !data_oe && !(f_in_valid && ctrl.periph_writes))
        else $error("port buffer used in extern mode");
    ext_irq_a: assert property ( // R20
        xfer_end && ext_on && ext_count_reg == `EPHS_CNT_W'(1) |=> done_irq)
        else $error("extern completion interrupt missing");
    pend_max_a: assert property ( // R25
        pend_reg == `EPHS_PEND_W'(`EPHS_MAX_PEND) && hs_on && !ctrl.request_flush_bit
        |=> pend_reg != '0) else $error("pending count wrapped");

    short_grant_c: cover property (
        grant_go ##1 (!xfer_grant_n && req_s) ##1 xfer_grant_n);
    pipelined_c: cover property (
        xfer_end && pend_reg > `EPHS_PEND_W'(1) ##[1:10] grant_go);
    ext_cycle_c: cover property (ext_on && xfer_end);
    blocked_c: cover property (state_reg == ephs_pkg::EPHS_ARB && blocked);
endmodule : ephs_top
`default_nettype wire

// file: core/ephs_cfg.svh
// constants for the external port dma handshake block
`ifndef EPHS_CFG_SVH
`define EPHS_CFG_SVH
`define EPHS_SYNC_STAGES 2
`define EPHS_GRANT_MIN_CYC 3
`define EPHS_ENA_IGNORE_CYC 2
`define EPHS_MAX_PEND 7
`define EPHS_PEND_W 3
`define EPHS_ADDR_W 32
`define EPHS_CNT_W 16
`define EPHS_MS_W 4
`define EPHS_WAIT_W 4
`define EPHS_FIFO_DEPTH 4
`define EPHS_DATA_W 32
`define EPHS_MS_IDLE 4'hf
`define EPHS_MS_SEL 4'he
`endif

// file: core/ephs_pkg.sv
// types shared by the external port dma handshake block
`include "ephs_cfg.svh"
package ephs_pkg;
    typedef struct packed {
        logic channel_enable_bit;
        logic handshake_mode_bit;
        logic initiator_mode_bit;
        logic extern_xfer_bit;
        logic periph_writes;
        logic request_flush_bit;
        logic chain_irq_disable;
    } ephs_ctrl_t;
    typedef struct packed {
        logic bus_owner;
        logic host_bus_grant;
        logic bus_suspend_in;
        logic host_bus_request;
        logic prio_pending;
        logic ack;
    } ephs_bus_t;
    typedef struct packed {
        logic [`EPHS_ADDR_W-1:0] addr;
        logic [`EPHS_MS_W-1:0] memory_select_lines;
        logic rd_n;
        logic wr_n;
    } ephs_ext_t;
    typedef enum logic [1:0] {
        EPHS_IDLE = 2'b00,
        EPHS_ARB = 2'b01,
        EPHS_GRANT = 2'b10
    } ephs_state_t;
endpackage : ephs_pkg

// file: core/ephs_sync.sv
// multi-stage synchroniser for the asynchronous request pin
`timescale 1ns/1ps
`default_nettype none
module ephs_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic [STAGES-1:0] sr_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sr_reg <= '1;
        end else begin
            sr_reg <= {sr_reg[STAGES-2:0], d};
        end
    end
    assign q = sr_reg[STAGES-1];
endmodule : ephs_sync
`default_nettype wire

// file: core/ephs_fifo.sv
// port buffer fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ephs_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    output logic full,
    output logic empty
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : ptr_inc

    assign full = (count_reg == (AW + 1)'(DEPTH));
    assign empty = (count_reg == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : ephs_fifo
`default_nettype wire

// file: tb/ephs_periph.sv
// far-side peripheral model for the request/grant pins
`timescale 1ns/1ps
`default_nettype none
module ephs_periph (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [7:0] hold_len,
    input wire logic [31:0] word,
    input wire logic grant_wire_n,
    input wire logic [31:0] data_out,
    output logic xfer_request_n,
    output logic [31:0] data_in,
    output logic [31:0] captured
);
    logic [7:0] low_left;
    logic grant_q;
    int owed;
    initial begin
        xfer_request_n = 1'b1;
        low_left = 8'h00;
        grant_q = 1'b1;
        owed = 0;
        captured = 32'h00000000;
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        grant_q <= grant_wire_n;
        owed <= owed + int'(go) - int'(grant_wire_n && !grant_q);
        if (!grant_wire_n) begin
            captured <= data_out;
        end
        if (go) begin
            xfer_request_n <= 1'b0;
            low_left <= hold_len;
        end else if (low_left > 8'h01) begin
            low_left <= low_left - 8'h01;
        end else begin
            xfer_request_n <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////
    // word valid until grant ends
    assign data_in = (owed > 0 || go) ? word : ~word;
endmodule : ephs_periph
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the dma request/grant block
`timescale 1ns/1ps
`default_nettype none
`include "ephs_cfg.svh"
module tb;
    logic clk_sys, rst_b, go, ext_load, int_in_valid, int_out_ready, gq, rq;
    logic xfer_request_n, xfer_grant_n, xfer_grant_oe, grant_wire_n;
    logic int_in_ready, int_out_valid, data_oe, bus_request, done_irq;
    logic [3:0] wait_states;
    logic [7:0] hold_len;
    logic [15:0] ext_count_in, words_left;
    logic [2:0] pending_count;
    logic [31:0] ext_index_in, ext_modifier_in, word, data_in, int_in_data;
    logic [31:0] int_out_data, data_out, captured, rnd;
    ephs_pkg::ephs_ctrl_t ctrl;
    ephs_pkg::ephs_bus_t bus;
    ephs_pkg::ephs_ext_t ext_bus;
    int miscompares = 0;
    int checked = 0;
    int pend = 0;
    int grants = 0;
    int since = 0;
    int glow = 0;
    int lat, gwidth, n;
    int exp_q[$];
    ////////////////////////////////////////////////////////////////
    ephs_top i_dut (.clk_sys, .rst_b, .ctrl, .bus, .xfer_request_n, .wait_states, .ext_load,
        .ext_index_in, .ext_modifier_in, .ext_count_in, .data_in, .int_in_valid, .int_in_data,
        .int_in_ready, .int_out_valid, .int_out_data, .int_out_ready, .xfer_grant_n,
        .xfer_grant_oe, .data_out, .data_oe, .ext_bus, .bus_request, .done_irq,
        .pending_count, .words_left);
    ephs_periph i_far (.clk_sys, .go, .hold_len, .word, .grant_wire_n, .data_out,
        .xfer_request_n, .data_in, .captured);
    // pull-up on the shared grant line
    assign grant_wire_n = xfer_grant_oe ? xfer_grant_n : 1'b1;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic fin(input string s);
        $display("test %s done, checked %0d", s, checked);
    endtask : fin
    task automatic new_word();
        rnd = xs(rnd);
        word <= rnd;
    endtask : new_word
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick
    task automatic req(input int hold);
        tick(1);
        go <= 1'b1;
        hold_len <= 8'(hold);
        tick(1);
        go <= 1'b0;
        tick(3);
        if (ctrl.channel_enable_bit && !ctrl.initiator_mode_bit && pend < 7) begin
            pend++;
            if (ctrl.periph_writes && !ctrl.extern_xfer_bit) exp_q.push_back(word);
        end
    endtask : req
    task automatic wait_grant();
        n = 0;
        while (grant_wire_n !== 1'b0 && n < 300) begin
            tick(1);
            n++;
        end
        chk(32'(grant_wire_n === 1'b0), 1, "grant wait");
    endtask : wait_grant
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        gq <= grant_wire_n;
        rq <= xfer_request_n;
        since = (rq && !xfer_request_n) ? 0 : since + 1;
        if (!grant_wire_n && gq) begin
            grants++;
            if (pend > 0) pend--;
            lat = since;
        end
        if (grant_wire_n && !gq) gwidth = glow;
        glow = grant_wire_n ? 0 : glow + 1;
        if (int_out_valid === 1'b1 && int_out_ready === 1'b1) begin
            chk(int_out_data, exp_q.pop_front(), "fifo word");
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        go = 1'b0;
        hold_len = 8'h01;
        rnd = 32'h9d3c389d;
        word = rnd;
        ctrl = 7'h64;
        bus = 6'h20;
        wait_states = 4'h0;
        ext_load = 1'b0;
        ext_index_in = 32'h00000000;
        ext_modifier_in = 32'h00000004;
        ext_count_in = 16'h0002;
        int_in_valid = 1'b0;
        int_in_data = 32'h00000000;
        int_out_ready = 1'b1;
        gq = 1'b1;
        rq = 1'b1;
        tick(12);
        rst_b <= 1'b1;
        tick(3);
        new_word();
        req(1);
        wait_grant();
        tick(4);
        chk(32'(lat >= 3), 1, "grant latency");
        chk(32'(gwidth), 1, "short grant");
        fin("short");
        req(12);
        wait_grant();
        while (xfer_request_n === 1'b0) begin
            chk(grant_wire_n, 0, "grant held");
            tick(1);
        end
        wait_grant();
        while (grant_wire_n === 1'b0 && n < 9) begin
            tick(1);
            n++;
        end
        chk(32'(n <= 4), 1, "grant release");
        fin("long");
        bus.bus_owner <= 1'b0;
        repeat (9) req(1);
        tick(2);
        chk(xfer_grant_oe, 0, "pin off bus");
        chk(pending_count, pend, "pending cap");
        ctrl.request_flush_bit <= 1'b1;
        tick(1);
        ctrl.request_flush_bit <= 1'b0;
        tick(2);
        chk(pending_count, 0, "flush");
        exp_q.delete();
        pend = 0;
        int_out_ready <= 1'b0;
        n = grants;
        repeat (5) req(1);
        bus.bus_owner <= 1'b1;
        tick(40);
        chk(grants - n, 4, "grants to full");
        chk(bus_request, 0, "full blocks");
        chk(pending_count, 1, "blocked kept");
        int_out_ready <= 1'b1;
        tick(20);
        chk(grants - n, 5, "drain unblocks");
        pend = 0;
        fin("queue");
        ctrl.periph_writes <= 1'b0;
        new_word();
        req(1);
        tick(20);
        chk(bus_request, 0, "empty blocks");
        bus.bus_suspend_in <= 1'b1;
        bus.prio_pending <= 1'b1;
        int_in_valid <= 1'b1;
        int_in_data <= rnd;
        tick(1);
        chk(int_in_ready, 1, "buffer accepts");
        int_in_valid <= 1'b0;
        tick(10);
        chk(grant_wire_n, 1, "suspend holds");
        bus.bus_suspend_in <= 1'b0;
        tick(5);
        chk(grant_wire_n, 1, "priority holds");
        bus.prio_pending <= 1'b0;
        wait_grant();
        chk(data_oe, 1, "data driven");
        tick(5);
        chk(captured, rnd, "read word");
        pend = 0;
        fin("read");
        ctrl <= 7'h6d;
        wait_states <= 4'h2;
        bus.ack <= 1'b1;
        ext_load <= 1'b1;
        ext_index_in <= rnd;
        tick(1);
        ext_load <= 1'b0;
        req(1);
        wait_grant();
        chk(ext_bus.memory_select_lines, `EPHS_MS_SEL, "select");
        chk(ext_bus.addr, rnd, "address");
        chk({ext_bus.rd_n, ext_bus.wr_n}, 2'b10, "strobes");
        tick(8);
        chk(32'(gwidth >= 3), 1, "waits");
        chk(words_left, 1, "count");
        chk(int_out_valid, 0, "no buffer");
        req(1);
        wait_grant();
        chk(ext_bus.addr, rnd + 32'h4, "next address");
        n = 0;
        while (done_irq !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk(done_irq, 1, "done pulse");
        fin("extern");
        ctrl <= 7'h74;
        tick(3);
        pend = 0;
        req(1);
        tick(8);
        chk(pending_count, 0, "initiator ignores");
        ctrl <= 7'h24;
        tick(3);
        chk(grant_wire_n, 1, "off grant high");
        chk(xfer_grant_oe, 1, "owner drives");
        req(1);
        tick(8);
        chk(pending_count, 0, "off ignores");
        bus.host_bus_grant <= 1'b1;
        tick(2);
        chk(xfer_grant_oe, 0, "host grant");
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(2);
        ctrl <= 7'h64;
        tick(8);
        chk(pending_count, 0, "enable ignores");
        fin("disable");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
